/* File: pkg/cptm_pkg.sv */
// package: constants and types for the compact 16-bit timer
`default_nettype none
package cptm_pkg;
  // ****************************************
  // clock figures
  // ****************************************
  localparam int unsigned SYS_CLK_HZ = 200_000_000; // system clock rate
  localparam int unsigned SUB_CLK_HZ = 32_768; // slow sub clock rate
  localparam int unsigned SUB_DIV_DEF = SYS_CLK_HZ / SUB_CLK_HZ; // sys cycles per sub tick
  localparam logic [5:0] DIV4_MASK = 6'h03; // sys/4 prescaler tap
  localparam logic [5:0] DIV16_MASK = 6'h0F; // high/16 prescaler tap
  localparam logic [5:0] DIV64_MASK = 6'h3F; // high/64 prescaler tap

  // ****************************************
  // register byte offsets on the bus
  // ****************************************
  localparam logic [11:0] OFS_RUN_CLK = 12'h000; // pause, clock select, on/off
  localparam logic [11:0] OFS_MODE_OUT = 12'h004; // mode and output control
  localparam logic [11:0] OFS_CNT_LO = 12'h008; // counter low byte (via buffer)
  localparam logic [11:0] OFS_CNT_HI = 12'h00C; // counter high byte
  localparam logic [11:0] OFS_CMPA_LO = 12'h010; // compare-A low byte (via buffer)
  localparam logic [11:0] OFS_CMPA_HI = 12'h014; // compare-A high byte
  localparam logic [11:0] OFS_PERIOD = 12'h018; // 8-bit period value
  localparam logic [11:0] OFS_STATUS = 12'h01C; // match flags, write one to clear
  localparam int unsigned STAT_A_BIT = 0; // compare-A match flag position
  localparam int unsigned STAT_P_BIT = 1; // compare-P match flag position

  // ****************************************
  // values after reset
  // ****************************************
  localparam logic [7:0] RUN_CLK_RST = 8'h00; // control word 0
  localparam logic [7:0] MODE_OUT_RST = 8'h00; // control word 1
  localparam logic [15:0] CNT_RST = 16'h0000; // counter
  localparam logic [15:0] CMPA_RST = 16'h0000; // compare-A
  localparam logic [7:0] PERIOD_RST = 8'h00; // period

  // ****************************************
  // encodings and carriers
  // ****************************************
  typedef enum logic [1:0] {
    MODE_CMP = 2'b00, // compare-match output
    MODE_UNDEF = 2'b01, // undefined, pin idle
    MODE_PWM = 2'b10, // edge-aligned pwm
    MODE_TMR = 2'b11 // timer/counter, pin unused
  } cptm_mode_t;

  typedef enum logic [2:0] {
    CK_SYS4 = 3'b000, CK_SYS = 3'b001, CK_H16 = 3'b010, CK_H64 = 3'b011,
    CK_SUB0 = 3'b100, CK_SUB1 = 3'b101, CK_PIN_RISE = 3'b110, CK_PIN_FALL = 3'b111
  } cptm_cksel_t;

  typedef struct packed {
    logic pause; // hold count
    cptm_cksel_t cksel; // clock_select_field
    logic on; // on_off_bit
    logic [2:0] rsvd; // read as zero
  } cptm_ctrl0_t;

  typedef struct packed {
    cptm_mode_t mode; // mode_field
    logic [1:0] iofn; // output_function_field
    logic oc; // output_control_bit
    logic pol; // polarity_bit
    logic dpx; // duty_period_select_bit
    logic ccl; // clear_select_bit
  } cptm_ctrl1_t;

  typedef struct packed {
    logic sel; // psel
    logic enable; // penable
    logic write; // pwrite
    logic [11:0] addr; // paddr
    logic [31:0] wdata; // pwdata
  } cptm_apb_req_t;

  typedef struct packed {
    cptm_ctrl0_t ctrl0; // control word 0
    cptm_ctrl1_t ctrl1; // control word 1
    logic [15:0] cnt; // live counter
    logic [15:0] cmpa; // compare_a_value
    logic [7:0] per; // period_value
    logic [7:0] hold; // shared low-byte buffer
    logic flag_a; // compare_a_match_flag
    logic flag_p; // compare_p_match_flag
    logic on_prev; // on bit one cycle ago
    logic pin; // pin level before polarity
    logic out; // registered pin drive
    logic [31:0] prdata; // read data
    logic pready; // transfer answer
    logic pslverr; // unmapped access
  } cptm_state_t;

  typedef struct packed {
    logic [5:0] pre; // free prescaler
    logic [15:0] sub; // sub clock divider
    logic [2:0] sync; // pin synchroniser and history
    logic tick; // count enable pulse
  } cptm_tick_state_t;
endpackage
`default_nettype wire

/* File: verilog/cptm_tick.sv */
// module: count clock selection and external pin edge detection
`timescale 1ns/1ps
`default_nettype none
module cptm_tick #(
  parameter int unsigned SUB_DIV = cptm_pkg::SUB_DIV_DEF // sys cycles per sub tick
) (
  input wire logic clk_in, // system clock
  input wire logic rstn_in, // async reset, active low
  input wire cptm_pkg::cptm_cksel_t sel_in, // selected count clock
  input wire logic pin_in, // external clock pin
  output logic tick_out // one-cycle count pulse
);
  import cptm_pkg::*;

  cptm_tick_state_t q; // registered state
  cptm_tick_state_t d; // next state
  logic sub_hit; // sub divider wraps
  logic rise; // synchronised rising edge
  logic fall; // synchronised falling edge

  // ****************************************
  // next state
  // ****************************************
  // prescalers run free so a switch of source needs no restart
  always_comb begin
    d = q;
    d.pre = q.pre + 6'd1;
    sub_hit = (q.sub == 16'(SUB_DIV - 1));
    d.sub = sub_hit ? 16'h0000 : q.sub + 16'd1;
    // first stage feeds only the second stage
    d.sync = {q.sync[1:0], pin_in};
    rise = q.sync[1] & ~q.sync[2];
    fall = ~q.sync[1] & q.sync[2];
    case (sel_in)
      CK_SYS4: d.tick = ((q.pre & DIV4_MASK) == DIV4_MASK);
      CK_SYS: d.tick = 1'b1;
      CK_H16: d.tick = ((q.pre & DIV16_MASK) == DIV16_MASK);
      CK_H64: d.tick = (q.pre == DIV64_MASK);
      CK_SUB0, CK_SUB1: d.tick = sub_hit;
      CK_PIN_RISE: d.tick = rise;
      CK_PIN_FALL: d.tick = fall;
      default: d.tick = 1'b0;
    endcase
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tick_out = q.tick;
endmodule
`default_nettype wire

/* File: verilog/cptm_top.sv */
// module: compact 16-bit timer with apb registers
// Notes on behaviour
// - low compare byte write only fills buffer
// - high byte write also moves buffer low
// - high byte read captures low into buffer
// - low byte read returns the buffer
// - 16-bit up counter steps on selected clock
// - P checks top byte, A all bits
// - counter self-clears on overflow or match
// - pause holds count, resume continues
// - three-bit field picks count clock
// - off holds count; on rising clears it
// - on rising restores initial pin level
// - two-bit field selects operating mode
// - compare mode: A match acts per field
// - pwm mode: field forces or enables waveform
// - control bit sets initial or active level
// - polarity bit inverts pin in compare and pwm modes
// - select bit swaps duty and period roles
// - clear-select picks P or A match
// - zero period means overflow, 65536 clocks
// - clear-select one never raises P flag outside pwm
// - compare-A zero overflows without A flag
// - only A match or switch-on moves pin in compare
`timescale 1ns/1ps
`default_nettype none
module cptm_top #(
  parameter int unsigned SUB_DIV = cptm_pkg::SUB_DIV_DEF // sys cycles per sub tick
) (
  input wire logic CLK_SYS_IN, // 200 MHz system clock
  input wire logic RSTN_IN, // async reset, active low
  input wire logic PSEL_IN, // apb select
  input wire logic PENABLE_IN, // apb access phase
  input wire logic PWRITE_IN, // apb direction
  input wire logic [11:0] PADDR_IN, // apb byte address
  input wire logic [31:0] PWDATA_IN, // apb write data
  output logic [31:0] PRDATA_OUT, // apb read data
  output logic PREADY_OUT, // apb answer
  output logic PSLVERR_OUT, // apb error
  input wire logic EXT_CLK_PIN_IN, // external_clock_pin
  output logic TIMER_PIN_OUT, // timer_output_pin
  output logic FLAG_A_OUT, // compare-A match flag
  output logic FLAG_P_OUT // compare-P match flag
);
  import cptm_pkg::*;

  // ****************************************
  // declarations
  // ****************************************
  cptm_state_t q; // registered state
  cptm_state_t d; // next state
  cptm_apb_req_t a; // bundled bus request
  logic tick; // count clock pulse
  logic load; // first access cycle: read data formed
  logic done; // completing edge of a transfer
  logic mapped; // address hits a register
  logic on_rise; // on bit went high
  logic step; // counter advances this cycle
  logic [16:0] nxt; // count plus one with carry
  logic hit_a; // comparator A match
  logic hit_p; // comparator P match
  logic pwm; // pwm mode selected
  logic clr; // counter clears instead of stepping
  logic set_a; // raise flag A
  logic set_p; // raise flag P
  logic clr_a; // software clears flag A
  logic clr_p; // software clears flag P
  logic [15:0] duty; // pwm duty threshold
  logic pwm_act; // pwm in active part

  assign a = '{sel: PSEL_IN, enable: PENABLE_IN, write: PWRITE_IN, addr: PADDR_IN, wdata: PWDATA_IN};

  // ****************************************
  // count clock source
  // ****************************************
  cptm_tick #(
    .SUB_DIV(SUB_DIV)
  ) u_tick (
    .clk_in(CLK_SYS_IN),
    .rstn_in(RSTN_IN),
    .sel_in(q.ctrl0.cksel),
    .pin_in(EXT_CLK_PIN_IN),
    .tick_out(tick)
  );

  // ****************************************
  // next state
  // ****************************************
  // one wait state buys a registered read bus
  always_comb begin
    d = q;
    clr_a = 1'b0;
    clr_p = 1'b0;
    load = a.sel & a.enable & ~q.pready;
    done = a.sel & a.enable & q.pready;
    mapped = (a.addr[11:5] == 7'h00) && (a.addr[1:0] == 2'b00);
    // answer one cycle after the access phase opens
    d.pready = load;
    d.pslverr = load & ~mapped;
    // reads are formed, with their side effects, on the load edge
    if (load) begin
      d.prdata = 32'h0000_0000;
      if (!a.write) begin
        case (a.addr)
          OFS_RUN_CLK: d.prdata[7:0] = q.ctrl0;
          OFS_MODE_OUT: d.prdata[7:0] = q.ctrl1;
          OFS_CNT_LO, OFS_CMPA_LO: d.prdata[7:0] = q.hold;
          OFS_CNT_HI: begin
            d.prdata[7:0] = q.cnt[15:8];
            d.hold = q.cnt[7:0];
          end
          OFS_CMPA_HI: begin
            d.prdata[7:0] = q.cmpa[15:8];
            d.hold = q.cmpa[7:0];
          end
          OFS_PERIOD: d.prdata[7:0] = q.per;
          OFS_STATUS: begin
            d.prdata[STAT_A_BIT] = q.flag_a;
            d.prdata[STAT_P_BIT] = q.flag_p;
          end
          default: d.prdata = 32'h0000_0000;
        endcase
      end
    end
    // writes take effect on the completing edge only
    if (done && a.write) begin
      case (a.addr)
        OFS_RUN_CLK: d.ctrl0 = cptm_ctrl0_t'({a.wdata[7:3], 3'b000});
        OFS_MODE_OUT: d.ctrl1 = cptm_ctrl1_t'(a.wdata[7:0]);
        OFS_CMPA_LO: d.hold = a.wdata[7:0];
        OFS_CMPA_HI: d.cmpa = {a.wdata[7:0], q.hold};
        OFS_PERIOD: d.per = a.wdata[7:0];
        OFS_STATUS: begin
          clr_a = a.wdata[STAT_A_BIT];
          clr_p = a.wdata[STAT_P_BIT];
        end
        // counter bytes are read only; a write only clears it by raising the on bit
        default: d.per = q.per;
      endcase
    end

    // counter: edge of on bit, pause and selected tick
    d.on_prev = q.ctrl0.on;
    on_rise = q.ctrl0.on & ~q.on_prev;
    step = q.ctrl0.on & ~q.ctrl0.pause & q.on_prev & tick;
    nxt = {1'b0, q.cnt} + 17'h0_0001;
    pwm = (q.ctrl1.mode == MODE_PWM);
    // zero compare-A never matches, the count simply wraps
    hit_a = (nxt[15:0] == q.cmpa) && (q.cmpa != 16'h0000);
    // zero period stands for a full 65536-clock wrap
    hit_p = (q.per != 8'h00) ? (nxt[15:0] == {q.per, 8'h00}) : nxt[16];
    if (pwm) begin
      // clear-select is ignored in pwm; dpx picks the period source
      clr = q.ctrl1.dpx ? hit_a : hit_p;
      set_a = step & hit_a;
      set_p = step & hit_p;
    end else begin
      clr = q.ctrl1.ccl ? hit_a : hit_p;
      set_a = step & hit_a;
      set_p = step & hit_p & ~q.ctrl1.ccl;
    end
    if (on_rise) begin
      d.cnt = CNT_RST;
    end else if (step) begin
      d.cnt = clr ? CNT_RST : nxt[15:0];
    end

    // flags: a set in the clearing cycle wins
    d.flag_a = (q.flag_a & ~clr_a) | set_a;
    d.flag_p = (q.flag_p & ~clr_p) | set_p;

    // pin level before polarity
    duty = q.ctrl1.dpx ? {q.per, 8'h00} : q.cmpa;
    pwm_act = (d.cnt < duty);
    if (on_rise) begin
      d.pin = q.ctrl1.oc;
    end else if (q.ctrl1.mode == MODE_CMP && set_a) begin
      // only comparator A moves the pin here
      case (q.ctrl1.iofn)
        2'b01: d.pin = 1'b0;
        2'b10: d.pin = 1'b1;
        2'b11: d.pin = ~q.pin;
        default: d.pin = q.pin;
      endcase
    end
    if (pwm && !on_rise) begin
      case (q.ctrl1.iofn)
        2'b00: d.pin = ~q.ctrl1.oc;
        2'b01: d.pin = q.ctrl1.oc;
        2'b10: d.pin = pwm_act ? q.ctrl1.oc : ~q.ctrl1.oc;
        default: d.pin = q.pin; // undefined setting holds
      endcase
    end
    // timer and undefined modes leave the pin low
    if (q.ctrl1.mode == MODE_CMP || pwm) begin
      d.out = d.pin ^ q.ctrl1.pol;
    end else begin
      d.out = 1'b0;
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      q <= '0;
      q.ctrl0 <= cptm_ctrl0_t'(RUN_CLK_RST);
      q.ctrl1 <= cptm_ctrl1_t'(MODE_OUT_RST);
      q.cmpa <= CMPA_RST;
      q.per <= PERIOD_RST;
    end else begin
      q <= d;
    end
  end

  // ****************************************
  // outputs, all from flip-flops
  // ****************************************
  assign PRDATA_OUT = q.prdata;
  assign PREADY_OUT = q.pready;
  assign PSLVERR_OUT = q.pslverr;
  assign TIMER_PIN_OUT = q.out;
  assign FLAG_A_OUT = q.flag_a;
  assign FLAG_P_OUT = q.flag_p;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge CLK_SYS_IN);
  endclocking
  default disable iff (!RSTN_IN);

  a_bus_one_wait: assert property (load |=> q.pready ##1 !q.pready)
    else $error("apb answer not exactly one cycle after access");
  a_low_write_buffer: assert property (done && a.write && a.addr == OFS_CMPA_LO
    |=> $stable(q.cmpa) && q.hold == $past(a.wdata[7:0]))
    else $error("low byte write touched compare value");
  a_high_write_pair: assert property (done && a.write && a.addr == OFS_CMPA_HI
    |=> q.cmpa == {$past(a.wdata[7:0]), $past(q.hold)})
    else $error("high byte write did not move buffer");
  a_high_read_capture: assert property (load && !a.write && a.addr == OFS_CNT_HI
    |=> q.hold == $past(q.cnt[7:0]) && q.prdata[7:0] == $past(q.cnt[15:8]))
    else $error("high byte read did not capture low byte");
  a_low_read_buffer: assert property (load && !a.write && a.addr == OFS_CNT_LO
    |=> q.prdata == {24'h00_0000, $past(q.hold)})
    else $error("low byte read not from buffer");
  a_count_step_one: assert property (q.cnt != $past(q.cnt) && q.cnt != 16'h0000
    |-> q.cnt == $past(q.cnt) + 16'd1)
    else $error("counter moved by other than one");
  a_pause_hold: assert property (q.ctrl0.pause && q.on_prev |=> $stable(q.cnt))
    else $error("counter moved while paused");
  a_on_rise_clear: assert property ($rose(q.ctrl0.on) |=> q.cnt == 16'h0000)
    else $error("counter not cleared on switch on");
  a_off_hold: assert property (!q.ctrl0.on |=> $stable(q.cnt))
    else $error("counter moved while off");
  a_period_clear: assert property (step && !pwm && !q.ctrl1.ccl && q.per != 8'h00
    && nxt[15:0] == {q.per, 8'h00} |=> q.cnt == 16'h0000 && q.flag_p)
    else $error("period match did not clear counter");
  a_no_p_flag: assert property (q.ctrl1.ccl && !pwm && !q.flag_p |=> !q.flag_p)
    else $error("compare-P flag raised with clear-select set");
  a_zero_cmpa_flag: assert property (q.cmpa == 16'h0000 && !q.flag_a |=> !q.flag_a)
    else $error("compare-A flag raised at zero compare");
  a_cmp_toggle: assert property (q.ctrl1.mode == MODE_CMP && q.ctrl1.iofn == 2'b11
    && set_a && !on_rise |=> q.pin == !$past(q.pin))
    else $error("toggle on compare-A match missing");
  a_init_level: assert property (on_rise && q.ctrl1.mode == MODE_CMP
    |=> q.pin == $past(q.ctrl1.oc) ##1 q.out == (q.pin ^ q.ctrl1.pol))
    else $error("pin not set to initial level on switch on");

  c_match_a: cover property (step && hit_a && q.ctrl1.mode == MODE_CMP);
  c_pwm_edge: cover property (pwm && $rose(q.out));
  c_pair_write: cover property (done && a.write && a.addr == OFS_CMPA_HI);
  c_wrap: cover property (step && nxt[16]);
endmodule
`default_nettype wire

/* File: bench/cptm_pin_model.sv */
// partner model: external count clock pin driven in bursts of pulses
`timescale 1ns/1ps
`default_nettype none
module cptm_pin_model (
  input wire logic clk_in, // system clock
  input wire logic rst_n_in, // reset, active low
  input wire logic go_in, // start a burst
  input wire logic [7:0] n_in, // pulses in the burst
  output logic pin_out, // external clock pin level
  output logic done_out // burst finished
);
  // ****************************************
  // burst generator
  // ****************************************
  int left = 0; // pulses still to send
  int ph = 0; // cycle within one pulse
  logic lvl = 1'b0; // pin level, idles low
  logic fin = 1'b1; // burst done
  assign pin_out = lvl;
  assign done_out = fin;
  // each level held four cycles, so the pin synchroniser cannot miss an edge
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      left <= 0;
      lvl <= 1'b0;
      fin <= 1'b1;
    end else if (go_in) begin
      left <= n_in;
      ph <= 0;
      fin <= 1'b0;
    end else if (left > 0) begin
      lvl <= (ph < 4);
      ph <= (ph + 1) % 8;
      if (ph == 7) begin
        left <= left - 1;
      end
    end else begin
      // pin stands still outside a burst
      lvl <= 1'b0;
      fin <= 1'b1;
    end
  end
endmodule
`default_nettype wire

/* File: bench/tb_top.sv */
// testbench: apb driven checks of the compact timer against a behavioural model
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import cptm_pkg::*;
  // ****************************************
  // clock, reset, bus and model state
  // ****************************************
  logic clk = 1'b0; // system clock
  logic rst_n = 1'b0; // reset, active low
  logic psel = 1'b0; // apb select
  logic pen = 1'b0; // apb enable
  logic pwr = 1'b0; // apb direction
  logic [11:0] padr = 12'h000; // apb address
  logic [31:0] pwd = 32'h0000_0000; // apb write data
  logic [31:0] prd; // apb read data
  logic prdy, perr, pin_tp, fla, flp, ext_pin, drv_done; // design and partner outputs
  logic drv_go = 1'b0; // partner burst start
  logic [7:0] drv_n = 8'h00; // partner pulse count
  int n_fail = 0, tests_run = 0, cyc = 0; // counters
  int c0 = 0, c1 = 0, cmpa = 0, per = 0, hold = 0; // register model, hold -1 means unknown
  always #2.5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  // small sub divider keeps the sub clock select fast
  cptm_top #(.SUB_DIV(4)) dut_u (.CLK_SYS_IN(clk), .RSTN_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(pen),
    .PWRITE_IN(pwr), .PADDR_IN(padr), .PWDATA_IN(pwd), .PRDATA_OUT(prd), .PREADY_OUT(prdy), .PSLVERR_OUT(perr),
    .EXT_CLK_PIN_IN(ext_pin), .TIMER_PIN_OUT(pin_tp), .FLAG_A_OUT(fla), .FLAG_P_OUT(flp));
  cptm_pin_model pm_u (.clk_in(clk), .rst_n_in(rst_n), .go_in(drv_go), .n_in(drv_n), .pin_out(ext_pin),
    .done_out(drv_done));
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      $display("unexpected %s: expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask
  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
    output logic er);
    int k;
    k = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    padr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (prdy !== 1'b1 && k < 20);
    r = prd;
    er = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    if (k >= 20) begin
      n_fail++;
      stop_test();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
    case (a)
      OFS_RUN_CLK: c0 = d[7:0] & 8'hF8;
      OFS_MODE_OUT: c1 = d[7:0];
      OFS_CMPA_LO: hold = d[7:0];
      OFS_CMPA_HI: cmpa = {d[7:0], hold[7:0]};
      OFS_PERIOD: per = d[7:0];
      default: ;
    endcase
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] r);
    logic e;
    int x;
    apb(1'b0, a, 32'h0000_0000, r, e);
    x = -1;
    case (a)
      OFS_RUN_CLK: x = c0;
      OFS_MODE_OUT: x = c1;
      OFS_CMPA_HI: begin
        x = cmpa >> 8;
        hold = cmpa & 255;
      end
      OFS_CMPA_LO, OFS_CNT_LO: x = hold;
      OFS_CNT_HI: hold = -1;
      OFS_PERIOD: x = per;
      default: ;
    endcase
    if (x >= 0) chk("read data", x, r);
  endtask
  // coherent counter read: high byte first
  task automatic cnt(output int v);
    logic [31:0] h, l;
    rd(OFS_CNT_HI, h);
    rd(OFS_CNT_LO, l);
    v = {h[7:0], l[7:0]};
  endtask
  task automatic highs(input int len, output int n);
    n = 0;
    repeat (len) begin
      @(negedge clk);
      n += (pin_tp === 1'b1);
    end
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    logic [31:0] r;
    logic e;
    int v, w, n, a, b, oc, pol, ex, t0, t1, dl, len, dd;
    int dv[6] = '{4, 1, 16, 64, 4, 4};
    void'($urandom(85));
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    // reset values, unmapped and read-only places
    rd(OFS_RUN_CLK, r);
    rd(OFS_MODE_OUT, r);
    rd(OFS_CMPA_HI, r);
    rd(OFS_CMPA_LO, r);
    rd(OFS_PERIOD, r);
    cnt(v);
    chk("count reset", 0, v);
    apb(1'b0, 12'h020, 32'h0000_0000, r, e);
    chk("unmapped error", 1, e);
    wr(OFS_CNT_HI, 32'h0000_00FF);
    rd(OFS_CNT_HI, r);
    chk("count read only", 0, r);
    // byte pairing through the shared buffer
    a = $urandom_range(255);
    b = $urandom_range(1, 255);
    wr(OFS_CMPA_LO, a);
    wr(OFS_CMPA_HI, b);
    rd(OFS_CMPA_HI, r);
    rd(OFS_CMPA_LO, r);
    wr(OFS_CMPA_LO, a ^ 8'h5A);
    rd(OFS_CMPA_HI, r);
    rd(OFS_CMPA_LO, r);
    // compare, undefined and timer modes against every output function
    for (int m = 0; m < 4; m++) begin
      for (int fn = 0; fn < 4; fn++) begin
        if (m != 2) begin
          dl = $urandom_range(20, 60);
          oc = $urandom_range(1);
          pol = $urandom_range(1);
          wr(OFS_RUN_CLK, 8'h10);
          wr(OFS_MODE_OUT, (m << 6) | (fn << 4) | (oc << 3) | (pol << 2) | 1);
          wr(OFS_CMPA_LO, dl);
          wr(OFS_CMPA_HI, 0);
          wr(OFS_STATUS, 3);
          wr(OFS_RUN_CLK, 8'h18);
          repeat (3) @(negedge clk);
          chk("initial pin", (m == 0) ? (oc ^ pol) : 0, pin_tp);
          n = 0;
          while (fla !== 1'b1 && n < 200) begin
            @(negedge clk);
            n++;
          end
          @(negedge clk);
          w = (fn == 0) ? oc : (fn == 1) ? 0 : (fn == 2) ? 1 : 1 - oc;
          chk("match pin", (m == 0) ? (w ^ pol) : 0, pin_tp);
          chk("flag a", 1, fla);
          chk("flag p", 0, flp);
          cnt(v);
          chk("cleared on match", 1, v < dl);
        end
      end
    end
    // pause and off hold the count, compare-A zero never flags
    wr(OFS_RUN_CLK, 8'h10);
    wr(OFS_MODE_OUT, 8'h01);
    wr(OFS_CMPA_LO, 0);
    wr(OFS_CMPA_HI, 0);
    wr(OFS_STATUS, 3);
    wr(OFS_RUN_CLK, 8'h18);
    repeat (50) @(posedge clk);
    wr(OFS_RUN_CLK, 8'h98);
    cnt(v);
    repeat (30) @(posedge clk);
    cnt(w);
    chk("paused count", v, w);
    chk("flag a zero", 0, fla);
    wr(OFS_RUN_CLK, 8'h18);
    repeat (40) @(posedge clk);
    wr(OFS_RUN_CLK, 8'h98);
    cnt(w);
    chk("resumed count", 1, w >= v + 40 && w <= v + 50);
    wr(OFS_RUN_CLK, 8'h10);
    repeat (20) @(posedge clk);
    cnt(v);
    chk("off count", w, v);
    wr(OFS_RUN_CLK, 8'h98);
    cnt(v);
    chk("on clears", 0, v);
    // clear-select low: period match clears at 256, both flags raised
    wr(OFS_RUN_CLK, 8'h10);
    wr(OFS_MODE_OUT, 8'h00);
    wr(OFS_CMPA_LO, 100);
    wr(OFS_CMPA_HI, 0);
    wr(OFS_PERIOD, 1);
    wr(OFS_STATUS, 3);
    wr(OFS_RUN_CLK, 8'h18);
    repeat (300) @(posedge clk);
    rd(OFS_STATUS, r);
    chk("period flags", 3, r[1:0]);
    cnt(v);
    chk("period wrap", 1, v < 256);
    // every clock select
    for (int s = 0; s < 8; s++) begin
      wr(OFS_RUN_CLK, s << 4);
      wr(OFS_RUN_CLK, (s << 4) | 8);
      t0 = cyc;
      if (s >= 6) begin
        n = $urandom_range(3, 10);
        drv_n <= n;
        drv_go <= 1'b1;
        @(posedge clk);
        drv_go <= 1'b0;
        repeat (2) @(posedge clk);
        for (int k = 0; k < 200 && drv_done !== 1'b1; k++) @(posedge clk);
        repeat (8) @(posedge clk);
      end else begin
        repeat (200) @(posedge clk);
      end
      wr(OFS_RUN_CLK, (s << 4) | 8'h88);
      t1 = cyc;
      cnt(v);
      ex = (s >= 6) ? n : (t1 - t0) / dv[(s >= 6) ? 0 : s];
      chk("count rate", 1, v - ex <= 2 && ex - v <= 2 && (s < 6 || v == n));
    end
    // pwm output functions in both duty/period roles
    for (int dx = 0; dx < 2; dx++) begin
      for (int fn = 0; fn < 3; fn++) begin
        oc = $urandom_range(1);
        pol = $urandom_range(1);
        dl = $urandom_range(10, 240);
        len = dx ? 512 : 256;
        dd = dx ? 256 : dl;
        wr(OFS_RUN_CLK, 8'h10);
        wr(OFS_MODE_OUT, 8'h80 | (fn << 4) | (oc << 3) | (pol << 2) | (dx << 1));
        wr(OFS_CMPA_LO, dx ? 0 : dl);
        wr(OFS_CMPA_HI, dx ? 2 : 0);
        wr(OFS_PERIOD, 1);
        wr(OFS_RUN_CLK, 8'h18);
        repeat (20) @(negedge clk);
        highs(len, n);
        a = oc ^ pol;
        b = 1 - a;
        ex = (fn == 0) ? b * len : (fn == 1) ? a * len : a * dd + b * (len - dd);
        chk("pwm high cycles", ex, n);
      end
    end
    stop_test();
  end
  // watchdog against a hung handshake or wait
  initial begin
    repeat (80000) @(posedge clk);
    n_fail++;
    stop_test();
  end
endmodule
`default_nettype wire
